// [irq_vector_map.sv]
// Interrupt request generation and vector mapping with AXI4-Lite access
`include "ivm_map.svh"
`default_nettype none
module irq_vector_map
  import ivm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [33:0] source_event,
  output logic irq_request,
  output logic nmi_request,
  output logic [5:0] vector_number,
  output logic [6:0] vector_address
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  flag_bank_if fb ();
  vec_mask_type irq_enable_reg;
  logic global_enable;
  logic split_mode;
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  pending_flag_bank u_bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .fb(fb)
  );

  // --------------------------------------------------------------------
  // Source to vector mapping
  // --------------------------------------------------------------------
  // Index of the event bus is the vector number; each vector is one
  // peripheral instance and any of its sources may drive that line
  vec_mask_type raw_event;
  assign raw_event[`IVM_VEC_RESET] = 1'b0;
  assign raw_event[`IVM_VEC_NMI] = source_event[`IVM_VEC_NMI];
  assign raw_event[`IVM_VEC_VLM] = source_event[`IVM_VEC_VLM];
  assign raw_event[`IVM_VEC_CFD] = source_event[`IVM_VEC_CFD];
  assign raw_event[`IVM_VEC_RTC] = source_event[`IVM_VEC_RTC];
  assign raw_event[`IVM_VEC_PIT] = source_event[`IVM_VEC_PIT];
  assign raw_event[`IVM_VEC_CUSTOM] =
    source_event[`IVM_VEC_CUSTOM];
  assign raw_event[`IVM_VEC_BUS_EVENT] =
    source_event[`IVM_VEC_BUS_EVENT];
  assign raw_event[`IVM_VEC_TRANS_DONE] =
    source_event[`IVM_VEC_TRANS_DONE];
  assign raw_event[`IVM_VEC_PORT_A] = source_event[`IVM_VEC_PORT_A];
  // Same line carries overflow (normal) or low underflow (split)
  assign raw_event[`IVM_VEC_TA_OVF] =
    source_event[`IVM_VEC_TA_OVF];
  // High underflow only exists in split mode
  assign raw_event[`IVM_VEC_TA_HUNF] =
    source_event[`IVM_VEC_TA_HUNF] & split_mode;
  assign raw_event[`IVM_VEC_TA_CMP2:`IVM_VEC_TA_CMP0] =
    source_event[`IVM_VEC_TA_CMP2:`IVM_VEC_TA_CMP0];
  assign raw_event[`IVM_VEC_LAST:`IVM_VEC_TYPE_B0] =
    source_event[`IVM_VEC_LAST:`IVM_VEC_TYPE_B0];

  // Flags set whatever the enables say
  assign fb.set = raw_event;

  // --------------------------------------------------------------------
  // Request generation and vector selection
  // --------------------------------------------------------------------
  vec_mask_type maskable;
  vec_mask_type active;
  logic nmi_pending;
  logic any_active;
  vec_num_type pick;

  // NMI and reset are never maskable
  assign maskable = {{(`IVM_NUM_VEC - 2){1'b1}}, 2'b00};
  assign active = fb.flags & irq_enable_reg & maskable &
    {`IVM_NUM_VEC{global_enable}};
  assign nmi_pending = fb.flags[`IVM_VEC_NMI];
  assign any_active = |active;

  // Lowest vector number wins; the NMI goes ahead of everything
  function automatic vec_num_type lowest(input vec_mask_type m);
    vec_num_type r;
    r = '0;
    for (int i = `IVM_NUM_VEC - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = vec_num_type'(i);
      end
    end
    return r;
  endfunction : lowest

  assign pick = nmi_pending ? `IVM_VEC_NMI : lowest(active);

  // Request level follows the enabled pending flags until software clears a flag or an enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request <= 1'b0;
      nmi_request <= 1'b0;
      vector_number <= '0;
      vector_address <= '0;
    end else begin
      irq_request <= any_active | nmi_pending;
      nmi_request <= nmi_pending;
      vector_number <= pick;
      vector_address <= {pick, 1'b0};
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------------
  // Address and data may arrive in either order; they are parked until
  // both are present, and the response is held until taken
  logic do_write;
  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;
  logic [31:0] wmask;
  logic wr_flag_lo;
  logic wr_flag_hi;
  logic wr_en_lo;
  logic wr_en_hi;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mapped;
  logic [31:0] wr_bits;

  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign next_aw_held = (aw_held & ~do_write) |
    (s_axi_awvalid & s_axi_awready);
  assign next_w_held = (w_held & ~do_write) | (s_axi_wvalid & s_axi_wready);
  assign next_bvalid = (s_axi_bvalid & ~s_axi_bready) | do_write;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}},
    {8{w_strb[0]}}};
  assign wr_bits = w_data & wmask;
  assign wr_flag_lo = {aw_addr[31:2], 2'b00} == `IVM_FLAG_LO_OFS;
  assign wr_flag_hi = {aw_addr[31:2], 2'b00} == `IVM_FLAG_HI_OFS;
  assign wr_en_lo = {aw_addr[31:2], 2'b00} == `IVM_EN_LO_OFS;
  assign wr_en_hi = {aw_addr[31:2], 2'b00} == `IVM_EN_HI_OFS;
  assign wr_ctrl = {aw_addr[31:2], 2'b00} == `IVM_CTRL_OFS;
  assign wr_status = {aw_addr[31:2], 2'b00} == `IVM_STATUS_OFS;
  assign wr_mapped = wr_flag_lo | wr_flag_hi | wr_en_lo | wr_en_hi |
    wr_ctrl | wr_status;

  // Writing a one clears a pending flag; the bank lets a new set win
  assign fb.clear = {
    (do_write & wr_flag_hi) ? wr_bits[1:0] : 2'b00,
    (do_write & wr_flag_lo) ? wr_bits : 32'h0000_0000
  };

  // Byte-lane merge of the enable words
  vec_mask_type next_enable;
  assign next_enable = {
    (do_write & wr_en_hi) ?
      ((irq_enable_reg[33:32] & ~wmask[1:0]) | wr_bits[1:0]) :
      irq_enable_reg[33:32],
    (do_write & wr_en_lo) ?
      ((irq_enable_reg[31:0] & ~wmask) | wr_bits) :
      irq_enable_reg[31:0]
  };

  // Parking registers for address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Ready drops while a beat is parked so one write is under way at most
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IVM_RESP_OKAY;
    end else begin
      s_axi_awready <= ~next_aw_held & ~next_bvalid;
      s_axi_wready <= ~next_w_held & ~next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (do_write) begin
        s_axi_bresp <= wr_mapped ? `IVM_RESP_OKAY : `IVM_RESP_SLVERR;
      end
    end
  end

  // Software-owned control bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_reg <= `IVM_ENABLE_RESET;
      global_enable <= 1'(`IVM_CTRL_RESET >> `IVM_CTRL_GLOBAL_BIT);
      split_mode <= 1'(`IVM_CTRL_RESET >> `IVM_CTRL_SPLIT_BIT);
    end else begin
      irq_enable_reg <= next_enable;
      if (do_write & wr_ctrl & w_strb[0]) begin
        global_enable <= w_data[`IVM_CTRL_GLOBAL_BIT];
        split_mode <= w_data[`IVM_CTRL_SPLIT_BIT];
      end
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------------
  logic ar_take;
  logic next_rvalid;
  logic [31:0] ar_word;
  logic rd_mapped;
  logic [31:0] rd_value;

  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign next_rvalid = (s_axi_rvalid & ~s_axi_rready) | ar_take;
  assign ar_word = {s_axi_araddr[31:2], 2'b00};
  assign rd_mapped = ar_word == `IVM_FLAG_LO_OFS ||
    ar_word == `IVM_FLAG_HI_OFS || ar_word == `IVM_EN_LO_OFS ||
    ar_word == `IVM_EN_HI_OFS || ar_word == `IVM_CTRL_OFS ||
    ar_word == `IVM_STATUS_OFS;
  // Unused bits read as zero; status shows the live request state
  assign rd_value =
    (ar_word == `IVM_FLAG_LO_OFS) ? fb.flags[31:0] :
    (ar_word == `IVM_FLAG_HI_OFS) ? {30'h0000_0000, fb.flags[33:32]} :
    (ar_word == `IVM_EN_LO_OFS) ? irq_enable_reg[31:0] :
    (ar_word == `IVM_EN_HI_OFS) ?
      {30'h0000_0000, irq_enable_reg[33:32]} :
    (ar_word == `IVM_CTRL_OFS) ? {30'h0000_0000, split_mode, global_enable} :
    (ar_word == `IVM_STATUS_OFS) ?
      {22'h00_0000, irq_request, nmi_request, 2'b00, vector_number} :
    32'h0000_0000;

  // Data is captured at the address handshake and held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `IVM_RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_mapped ? `IVM_RESP_OKAY : `IVM_RESP_SLVERR;
      end
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence event_seen;
    fb.set != '0;
  endsequence
  sequence maskable_pending;
    any_active;
  endsequence

  flag_capture_a: assert property (event_seen |=>
    ((fb.flags & $past(fb.set)) == $past(fb.set)))
    else $error("event did not set its flag");
  flag_no_enable_a: assert property (
    (raw_event & ~irq_enable_reg) != '0
    |=> (fb.flags & $past(raw_event)) != '0)
    else $error("disabled source flag not set");
  enable_write_a: assert property (do_write && wr_en_lo &&
    w_strb == 4'hF |=> irq_enable_reg[31:0] == $past(w_data))
    else $error("enable word not stored");
  request_cause_a: assert property (!any_active && !nmi_pending
    |=> !irq_request)
    else $error("request with no enabled flag");
  enabled_request_a: assert property (any_active |=> irq_request)
    else $error("enabled pending flag gave no request");
  global_gate_a: assert property (!global_enable && !nmi_pending
    |=> !irq_request)
    else $error("request while globally disabled");
  request_hold_a: assert property (
    maskable_pending ##1 maskable_pending |-> irq_request)
    else $error("request dropped while flag pending");
  // A clear that no new event overrides must empty the flag at once
  flag_clear_a: assert property ((fb.clear & ~fb.set) != '0 |=>
    (fb.flags & $past(fb.clear & ~fb.set)) == '0)
    else $error("cleared flag still pending");
  // Priority is checked bit by bit, not through the picking function
  lowest_wins_a: assert property (any_active && !nmi_pending |=>
    (($past(active) >> vector_number) & 34'h1) == 34'h1 &&
    ($past(active) & ((34'h1 << vector_number) - 34'h1)) == '0)
    else $error("vector is not the lowest active one");
  nmi_vector_a: assert property (nmi_pending |=>
    nmi_request && irq_request && vector_number == `IVM_VEC_NMI)
    else $error("non-maskable vector wrong");
  vector_addr_a: assert property (irq_request |->
    vector_address == {vector_number, 1'b0})
    else $error("word address not twice vector");
  hunf_normal_a: assert property (!split_mode &&
    !fb.flags[`IVM_VEC_TA_HUNF] |=> !fb.flags[`IVM_VEC_TA_HUNF])
    else $error("high underflow set in normal mode");
  write_resp_a: assert property (do_write |=> s_axi_bvalid)
    else $error("write response missing");
  read_resp_a: assert property (ar_take |=> s_axi_rvalid)
    else $error("read data missing");

endmodule : irq_vector_map
`default_nettype wire

// [ivm_map.svh]
// Address map, field positions, reset values and vector numbers
//
// Behaviour
// - A peripheral's interrupt condition sets its pending flag.
// - Pending flags set whether or not the source is enabled.
// - Software writes per-source enable bits to enable or disable sources.
// - A maskable request exists only while enable and pending flag are both set.
// - Maskable requests are suppressed unless the global enable is set.
// - A request holds until software clears its pending flag, or its enable bit or the global enable.
// - Each vector belongs to one peripheral; its sources may share it.
// - Vector 1 at word address 0x02 serves the non-maskable interrupt.
// - Vector 2 at word 0x04 serves the supply voltage monitor.
// - Vector 3 at word 0x06 serves clock source failure detection.
// - Vector 4 at word 0x08 serves real-time counter overflow/compare.
// - Vector 5 at word 0x0A serves the real-time periodic tick.
// - Vector 6 at word 0x0C serves the custom logic interrupt.
// - Vector 7 at word 0x0E serves the serial bus event interrupt.
// - Vector 8 at word 0x10 serves serial bus transaction complete.
// - Vector 10 serves timer A overflow, or low underflow in split mode.
// - Vector 11 serves timer A high underflow, unused in normal mode.
// - Vectors 12 to 14 serve timer A compare channels 0 to 2.
// - Vectors 15 to 33 serve remaining peripherals, ending at word 0x42.
`ifndef IVM_MAP_SVH
`define IVM_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define IVM_FLAG_LO_OFS 32'h0000_0000
`define IVM_FLAG_HI_OFS 32'h0000_0004
`define IVM_EN_LO_OFS 32'h0000_0008
`define IVM_EN_HI_OFS 32'h0000_000C
`define IVM_CTRL_OFS 32'h0000_0010
`define IVM_STATUS_OFS 32'h0000_0014

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define IVM_CTRL_GLOBAL_BIT 0
`define IVM_CTRL_SPLIT_BIT 1
`define IVM_STATUS_NMI_BIT 8
`define IVM_STATUS_REQ_BIT 9
`define IVM_CTRL_RESET 2'h0
`define IVM_ENABLE_RESET 34'h0_0000_0000
`define IVM_RESP_OKAY 2'h0
`define IVM_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Vector numbers
// ----------------------------------------------------------------------
`define IVM_NUM_VEC 34
`define IVM_VEC_RESET 6'h00
`define IVM_VEC_NMI 6'h01
`define IVM_VEC_VLM 6'h02
`define IVM_VEC_CFD 6'h03
`define IVM_VEC_RTC 6'h04
`define IVM_VEC_PIT 6'h05
`define IVM_VEC_CUSTOM 6'h06
`define IVM_VEC_BUS_EVENT 6'h07
`define IVM_VEC_TRANS_DONE 6'h08
`define IVM_VEC_PORT_A 6'h09
`define IVM_VEC_TA_OVF 6'h0A
`define IVM_VEC_TA_HUNF 6'h0B
`define IVM_VEC_TA_CMP0 6'h0C
`define IVM_VEC_TA_CMP2 6'h0E
`define IVM_VEC_TYPE_B0 6'h0F
`define IVM_VEC_LAST 6'h21

`endif

// [ivm_pkg.sv]
// Types shared by the interrupt vector mapping block
`default_nettype none
package ivm_pkg;
  typedef logic [5:0] vec_num_type;
  typedef logic [6:0] word_addr_type;
  typedef logic [33:0] vec_mask_type;
endpackage : ivm_pkg
`default_nettype wire

// [flag_bank_if.sv]
// Carrier between the register logic and the pending flag bank
`default_nettype none
interface flag_bank_if;
  import ivm_pkg::*;
  vec_mask_type set;
  vec_mask_type clear;
  vec_mask_type flags;
  modport bank (input set, input clear, output flags);
  modport ctrl (output set, output clear, input flags);
endinterface : flag_bank_if
`default_nettype wire

// [pending_flag_bank.sv]
// Sticky pending flags, one per vector
`default_nettype none
module pending_flag_bank
  import ivm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  flag_bank_if.bank fb
);
  vec_mask_type pending_flag_reg;
  vec_mask_type next_flags;

  // Set beats a clear in the same cycle so no event is lost
  assign next_flags = (pending_flag_reg & ~fb.clear) | fb.set;
  assign fb.flags = pending_flag_reg;

  // Flags hold until cleared by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_flag_reg <= '0;
    end else begin
      pending_flag_reg <= next_flags;
    end
  end
endmodule : pending_flag_bank
`default_nettype wire

// [core_fetch_model.sv]
// Processor core model that fetches the vector behind each new request
`default_nettype none
module core_fetch_model
  import ivm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_request,
  input wire logic [5:0] vector_number,
  input wire logic [6:0] vector_address,
  input wire logic [1:0] fetch_delay,
  output var logic fetch_valid,
  output var vec_num_type fetch_vector,
  output var word_addr_type fetch_address
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen;
  logic busy;
  logic [1:0] wait_cnt;
  // ----------------------------------------------------------------
  // Fetch sequencer
  // ----------------------------------------------------------------
  // Answers each new request after a chosen delay, so a slow core is
  // covered too; the vector is taken once per rising request
  always_ff @(posedge aclk) begin
    fetch_valid <= 1'b0;
    if (!aresetn) begin
      seen <= 1'b0;
      busy <= 1'b0;
      wait_cnt <= 2'h0;
      fetch_vector <= 6'h00;
      fetch_address <= 7'h00;
    end else begin
      seen <= irq_request;
      if (irq_request && !seen) begin
        busy <= 1'b1;
        wait_cnt <= fetch_delay;
      end else if (busy && wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (busy) begin
        busy <= 1'b0;
        fetch_valid <= 1'b1;
        fetch_vector <= vector_number;
        fetch_address <= vector_address;
      end
    end
  end
endmodule : core_fetch_model
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the interrupt vector mapping block
`include "ivm_map.svh"
`default_nettype none
module testbench
  import ivm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, fetch_delay;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, irq_request, nmi_request, fetch_valid;
  logic [33:0] source_event;
  vec_num_type vector_number, fetch_vector, exp_v;
  word_addr_type vector_address, fetch_address;
  vec_num_type exp_q[$];
  vec_mask_type m;
  int mismatches, checks, seed, v, i, e, ev;

  irq_vector_map dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .source_event,
    .irq_request, .nmi_request, .vector_number, .vector_address);
  core_fetch_model core_u (.aclk, .aresetn, .irq_request, .vector_number,
    .vector_address, .fetch_delay, .fetch_valid, .fetch_vector,
    .fetch_address);

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic hung;
    mismatches++;
    results();
  endtask : hung

  // ----------------------------------------------------------------
  // Bus cycles and events
  // ----------------------------------------------------------------
  // Address and data go out together; each drops once taken
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 40) hung();
    s_axi_bready <= 1'b0;
    check(34'(s_axi_bresp), 34'(er));
  endtask : wr

  task automatic rd(input logic [31:0] a, ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 40) hung();
    s_axi_rready <= 1'b0;
    check(34'(s_axi_rdata), 34'(ed));
    check(34'(s_axi_rresp), 34'(er));
  endtask : rd

  // Long settle so the core has fetched before anything is cleared
  task automatic pulse(input vec_mask_type p);
    @(posedge aclk);
    source_event <= p;
    fetch_delay <= 2'($random(seed));
    @(posedge aclk);
    source_event <= '0;
    repeat (8) @(posedge aclk);
    @(negedge aclk);
  endtask : pulse

  task automatic clr(input vec_mask_type p);
    wr(`IVM_FLAG_LO_OFS, p[31:0], `IVM_RESP_OKAY);
    wr(`IVM_FLAG_HI_OFS, {30'h0, p[33:32]}, `IVM_RESP_OKAY);
    @(negedge aclk);
  endtask : clr

  // Each fetch by the core takes the oldest expected vector
  always @(negedge aclk) begin
    if (fetch_valid === 1'b1) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 6'h3F;
      check(34'(fetch_vector), 34'(exp_v));
      check(34'(fetch_address), 34'({exp_v, 1'b0}));
    end
  end

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  initial begin
    #2000000;
    hung();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h5804;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    source_event = '0;
    fetch_delay = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`IVM_CTRL_OFS, 32'h0, `IVM_RESP_OKAY);
    rd(`IVM_EN_LO_OFS, 32'h0, `IVM_RESP_OKAY);
    rd(32'h0000_0020, 32'h0, `IVM_RESP_SLVERR);
    wr(32'h0000_0020, 32'hFFFF_FFFF, `IVM_RESP_SLVERR);
    pulse(34'h0_0000_0800);
    rd(`IVM_FLAG_LO_OFS, 32'h0, `IVM_RESP_OKAY);
    pulse(34'h0_0000_0020);
    rd(`IVM_FLAG_LO_OFS, 32'h20, `IVM_RESP_OKAY);
    check(34'(irq_request), 34'h0);
    wr(`IVM_EN_LO_OFS, 32'h20, `IVM_RESP_OKAY);
    check(34'(irq_request), 34'h0);
    exp_q.push_back(`IVM_VEC_PIT);
    wr(`IVM_CTRL_OFS, 32'h1, `IVM_RESP_OKAY);
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    check(34'(vector_address), 34'h0A);
    wr(`IVM_EN_LO_OFS, 32'h0, `IVM_RESP_OKAY);
    @(negedge aclk);
    check(34'(irq_request), 34'h0);
    clr(34'h20);
    // Split mode, every source enabled, one vector at a time
    wr(`IVM_CTRL_OFS, 32'h3, `IVM_RESP_OKAY);
    wr(`IVM_EN_LO_OFS, 32'hFFFF_FFFF, `IVM_RESP_OKAY);
    wr(`IVM_EN_HI_OFS, 32'h3, `IVM_RESP_OKAY);
    for (v = 1; v < `IVM_NUM_VEC; v++) begin
      exp_q.push_back(6'(v));
      pulse(34'h1 << v);
      check(34'(vector_address), 34'(2 * v));
      check(34'(nmi_request), 34'(v == 1));
      check(34'(irq_request), 34'h1);
      clr(34'h1 << v);
      check(34'(irq_request), 34'h0);
    end
    // Global enable off: only the non-maskable source gets through
    wr(`IVM_CTRL_OFS, 32'h2, `IVM_RESP_OKAY);
    exp_q.push_back(`IVM_VEC_NMI);
    pulse(34'h12);
    check(34'(nmi_request), 34'h1);
    clr(34'h2);
    check(34'(irq_request), 34'h0);
    exp_q.push_back(`IVM_VEC_RTC);
    wr(`IVM_CTRL_OFS, 32'h3, `IVM_RESP_OKAY);
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    check(34'(vector_number), 34'h4);
    rd(`IVM_STATUS_OFS, 32'h0000_0204, `IVM_RESP_OKAY);
    rd(`IVM_EN_HI_OFS, 32'h3, `IVM_RESP_OKAY);
    clr(34'h10);
    // Random groups of sources: the lowest vector wins
    for (i = 0; i < 8; i++) begin
      m = 34'({$random(seed), $random(seed)}) & 34'h3_FFFF_FFFE;
      for (e = 33; e > 0; e--) if (m[e]) ev = e;
      exp_q.push_back(6'(ev));
      pulse(m);
      check(34'(vector_number), 34'(ev));
      rd(`IVM_FLAG_LO_OFS, m[31:0], `IVM_RESP_OKAY);
      rd(`IVM_FLAG_HI_OFS, 32'(m[33:32]), `IVM_RESP_OKAY);
      clr(m);
    end
    // One byte lane only: the other enable bytes must keep their value
    s_axi_wstrb <= 4'h2;
    wr(`IVM_EN_LO_OFS, 32'h0, `IVM_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(`IVM_EN_LO_OFS, 32'hFFFF_00FF, `IVM_RESP_OKAY);
    // Mid-run reset with a request up: flags and enables return to zero
    exp_q.push_back(`IVM_VEC_PIT);
    pulse(34'h20);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`IVM_FLAG_LO_OFS, 32'h0, `IVM_RESP_OKAY);
    rd(`IVM_EN_LO_OFS, 32'h0, `IVM_RESP_OKAY);
    check(34'(irq_request), 34'h0);
    repeat (10) @(posedge aclk);
    check(34'(exp_q.size()), 34'h0);
    results();
  end
endmodule : testbench
`default_nettype wire
